// ---- rtl/hotswap_fault_supervisor_map.vh ----
// Command codes, field positions, reset values and timing for the supervisor.
`ifndef HOTSWAP_FAULT_SUPERVISOR_MAP_VH
`define HOTSWAP_FAULT_SUPERVISOR_MAP_VH

// ********************************************************************
// Management bus command codes
// ********************************************************************
`define CMD_OUTPUT_ON_OFF 8'h03
`define CMD_CLEAR_FLAGS 8'h05
`define CMD_OVERTEMP_FAULT_LIMIT 8'h4f
`define CMD_OVERTEMP_WARN_LIMIT 8'h51
`define CMD_VENDOR_STATUS_BYTE 8'h80
`define CMD_TEMPERATURE_READING 8'h8d
`define CMD_ALERT_SUPPRESS_MASK 8'hd8
`define CMD_DEVICE_SETUP 8'hd9
`define CMD_DIAGNOSTIC_STATUS 8'he1

// ********************************************************************
// Values and fields
// ********************************************************************
`define OUTPUT_ON_VALUE 8'h80
`define OUTPUT_OFF_VALUE 8'h00
`define OUTPUT_ON_OFF_RST 8'h80
`define OVERTEMP_WARN_RST 16'h007d
`define OVERTEMP_FAULT_RST 16'h0096
`define ALERT_MASK_RST 16'h0000
`define DEVICE_SETUP_RST 8'h00
`define VENDOR_SHORTED_BIT 7
`define DIAG_SHORTED_BIT 7
`define DIAG_OT_FAULT_BIT 6
`define DIAG_OT_WARN_BIT 5
`define DIAG_LATCHED_OFF_BIT 4
`define DIAG_UNDERVOLT_BIT 3
`define DIAG_OVERVOLT_BIT 2
`define RETRY_INFINITE 3'h6

// ********************************************************************
// Timing
// ********************************************************************
`define CLK_PERIOD_NS 5
`define TEMP_PERIOD_NS 1000000
`define BIAS_PULSE_NS 10000
`define TEMP_PERIOD_CYC (`TEMP_PERIOD_NS / `CLK_PERIOD_NS)
`define BIAS_PULSE_CYC (`BIAS_PULSE_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/smbus_target.v ----
// Byte-level management bus target: address match, write bytes, word reads.
`timescale 1ns/1ps
module smbus_target (
  input wire clk_in,
  input wire reset_n_in,
  input wire scl_in,
  input wire sda_in,
  input wire [6:0] own_addr_in,
  input wire addr_valid_in,
  input wire [15:0] rd_data_in,
  output reg sda_oe_out,
  output reg byte_stb_out,
  output reg [1:0] byte_idx_out,
  output reg [7:0] byte_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK_A = 3'd2;
  localparam ST_WRB = 3'd3;
  localparam ST_ACK_W = 3'd4;
  localparam ST_RDB = 3'd5;
  localparam ST_ACK_R = 3'd6;

  // ********
  // Pin synchronisers
  // ********
  // Bit 0 is the first flop; only bit 0 -> bit 1 reads it.
  reg [2:0] scl_s_q;
  reg [2:0] sda_s_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  // Edge and condition decode on the settled copies.
  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire bus_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  wire bus_stop = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  // ********
  // Byte engine
  // ********
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg rd_hi_q;
  reg ack_ok_q;

  // SDA only changes after SCL falls, so a start or stop is never faked.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rd_hi_q <= 1'b0;
      ack_ok_q <= 1'b0;
      sda_oe_out <= 1'b0;
      byte_stb_out <= 1'b0;
      byte_idx_out <= 2'h0;
      byte_out <= 8'h00;
    end else begin
      byte_stb_out <= 1'b0;
      if (bus_start) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == ST_ADDR || state_q == ST_WRB) begin
          shift_q <= {shift_q[6:0], sda_s_q[1]};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == ST_ACK_R) begin
          ack_ok_q <= ~sda_s_q[1];
        end
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              if (addr_valid_in && shift_q[7:1] == own_addr_in) begin
                sda_oe_out <= 1'b1;
                bit_cnt_q <= 4'h0;
                state_q <= shift_q[0] ? ST_RDB : ST_ACK_A;
                rd_hi_q <= 1'b0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            sda_oe_out <= 1'b0;
            bit_cnt_q <= 4'h0;
            byte_idx_out <= 2'h0;
            state_q <= ST_WRB;
          end
          ST_WRB: begin
            if (bit_cnt_q == 4'h8) begin
              byte_out <= shift_q;
              byte_stb_out <= 1'b1;
              sda_oe_out <= 1'b1;
              state_q <= ST_ACK_W;
            end
          end
          ST_ACK_W: begin
            sda_oe_out <= 1'b0;
            bit_cnt_q <= 4'h0;
            if (byte_idx_out != 2'h2) begin
              byte_idx_out <= byte_idx_out + 2'h1;
            end
            state_q <= ST_WRB;
          end
          ST_RDB: begin
            // Entered with the address ack driven; first fall loads data.
            if (bit_cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              state_q <= ST_ACK_R;
            end else begin
              if (bit_cnt_q == 4'h0) begin
                tx_q <= rd_hi_q ? {rd_data_in[14:8], 1'b0} :
                                  {rd_data_in[6:0], 1'b0};
                sda_oe_out <= rd_hi_q ? ~rd_data_in[15] : ~rd_data_in[7];
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_out <= ~tx_q[7];
              end
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          ST_ACK_R: begin
            if (ack_ok_q) begin
              rd_hi_q <= 1'b1;
              bit_cnt_q <= 4'h1;
              tx_q <= {rd_data_in[14:8], 1'b0};
              sda_oe_out <= ~rd_data_in[15];
              state_q <= ST_RDB;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // smbus_target

// ---- rtl/hotswap_fault_supervisor.v ----
// Hot-swap supervisor: temperature, shorted switch, gate and retry control.
// Functional notes
// - One bias pulse per period; the diode code step gives the sample.
// - The temperature read command returns the latest sample.
// - A sample above the warning limit sets a flag that drives the alert.
// - A sample above the fault limit latches a trip that turns the gate off.
// - Written warning and fault limits apply to every later comparison.
// - Sense high with the gate low or commanded low sets the shorted flag.
// - The shorted flag drives the alert unless its mask bit is set.
// - Enable low or overvoltage high forces the gate off at any time.
// - A low-then-high toggle of the enable input clears latch-off unless a fault timeout outside the unlimited setting lands in the same cycle.
// - The enable and overvoltage pins never alter address or settings.
// - Writing the on value enables the output; writing zero disables it.
// - Three three-level straps give the address, latched at supply good.
// - Reset erases settings and defers address capture to supply good.
// - The retry setting allows 0, 1, 2, 4, 8, 16 or unlimited restarts.
// - The diagnostic latched-off bit reads high while latch-off lasts.
`timescale 1ns/1ps
`include "hotswap_fault_supervisor_map.vh"
module hotswap_fault_supervisor #(
  parameter TEMP_PERIOD_CYC = `TEMP_PERIOD_CYC,
  parameter BIAS_PULSE_CYC = `BIAS_PULSE_CYC,
  parameter [6:0] ADDR_BASE = 7'h40
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output wire sda_oe_out,
  output reg smb_alert_out,
  output reg smb_alert_oe_out,
  input wire [15:0] diode_code_in,
  output reg bias_pulse_out,
  input wire undervoltage_enable_input,
  input wire overvoltage_input,
  input wire sense_over_short_in,
  input wire gate_low_in,
  input wire fault_timeout_in,
  input wire supply_ready_in,
  input wire [1:0] address_strap_a,
  input wire [1:0] address_strap_b,
  input wire [1:0] address_strap_c,
  output reg gate_on_out
);

  // Ternary strap digit: ground 0, open 1, tied high 2.
  function [6:0] strap_digit;
    input [1:0] level;
    begin
      strap_digit = (level[1]) ? 7'd2 : {6'h00, level[0]};
    end
  endfunction

  // Retry limit for a setting code; unlimited is handled separately.
  function [4:0] retry_limit;
    input [2:0] code;
    begin
      case (code)
        3'h0: retry_limit = 5'd0;
        3'h1: retry_limit = 5'd1;
        3'h2: retry_limit = 5'd2;
        3'h3: retry_limit = 5'd4;
        3'h4: retry_limit = 5'd8;
        3'h5: retry_limit = 5'd16;
        default: retry_limit = 5'd16;
      endcase
    end
  endfunction

  // ********
  // Pin synchronisers
  // ********
  // Two flops per slow pin. The enable bit resets to its idle high so that
  // a release is no false undervoltage; the gate waits for supply instead.
  reg [11:0] pin_s1_q;
  reg [11:0] pin_s2_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_q <= 12'h001;
      pin_s2_q <= 12'h001;
    end else begin
      pin_s1_q <= {address_strap_c, address_strap_b, address_strap_a,
                   supply_ready_in, fault_timeout_in, gate_low_in,
                   sense_over_short_in, overvoltage_input,
                   undervoltage_enable_input};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire uv_ok = pin_s2_q[0];
  wire ov_high = pin_s2_q[1];
  wire sense_short = pin_s2_q[2];
  wire gate_low = pin_s2_q[3];
  wire timeout_lvl = pin_s2_q[4];
  wire supply_ok = pin_s2_q[5];

  // ********
  // Address capture
  // ********
  reg [6:0] addr_q;
  reg addr_valid_q;
  // Latched once after reset release; reset itself is the re-capture path.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_q <= 7'h00;
      addr_valid_q <= 1'b0;
    end else if (!addr_valid_q && supply_ok) begin
      addr_q <= ADDR_BASE + strap_digit(pin_s2_q[7:6]) +
                7'd3 * strap_digit(pin_s2_q[9:8]) +
                7'd9 * strap_digit(pin_s2_q[11:10]);
      addr_valid_q <= 1'b1;
    end
  end

  // ********
  // Management bus target and register writes
  // ********
  wire byte_stb;
  wire [1:0] byte_idx;
  wire [7:0] byte_val;
  reg [15:0] rd_data;
  smbus_target u_target (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .own_addr_in(addr_q),
    .addr_valid_in(addr_valid_q),
    .rd_data_in(rd_data),
    .sda_oe_out(sda_oe_out),
    .byte_stb_out(byte_stb),
    .byte_idx_out(byte_idx),
    .byte_out(byte_val)
  );

  reg [7:0] cmd_q;
  reg [7:0] low_byte_q;
  reg [7:0] output_on_off_q;
  reg [15:0] overtemp_fault_limit_q;
  reg [15:0] overtemp_warn_limit_q;
  reg [15:0] alert_suppress_mask_q;
  reg [7:0] device_setup_q;
  wire stb_cmd = byte_stb && byte_idx == 2'h0;
  wire stb_lo = byte_stb && byte_idx == 2'h1;
  wire stb_hi = byte_stb && byte_idx == 2'h2;
  wire clear_cmd = stb_cmd && byte_val == `CMD_CLEAR_FLAGS;

  // Word registers commit on the high byte, so a half write changes nothing.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= 8'h00;
      low_byte_q <= 8'h00;
      output_on_off_q <= `OUTPUT_ON_OFF_RST;
      overtemp_fault_limit_q <= `OVERTEMP_FAULT_RST;
      overtemp_warn_limit_q <= `OVERTEMP_WARN_RST;
      alert_suppress_mask_q <= `ALERT_MASK_RST;
      device_setup_q <= `DEVICE_SETUP_RST;
    end else begin
      if (stb_cmd) begin
        cmd_q <= byte_val;
      end
      if (stb_lo) begin
        low_byte_q <= byte_val;
        if (cmd_q == `CMD_OUTPUT_ON_OFF) begin
          output_on_off_q <= byte_val;
        end
        if (cmd_q == `CMD_DEVICE_SETUP) begin
          device_setup_q <= byte_val;
        end
      end
      if (stb_hi) begin
        case (cmd_q)
          `CMD_OVERTEMP_FAULT_LIMIT: begin
            overtemp_fault_limit_q <= {byte_val, low_byte_q};
          end
          `CMD_OVERTEMP_WARN_LIMIT: begin
            overtemp_warn_limit_q <= {byte_val, low_byte_q};
          end
          `CMD_ALERT_SUPPRESS_MASK: begin
            alert_suppress_mask_q <= {byte_val, low_byte_q};
          end
          default: low_byte_q <= low_byte_q;
        endcase
      end
    end
  end
  // The enable and overvoltage pins reach none of the registers above.

  // ********
  // Temperature measurement
  // ********
  reg [31:0] meas_cnt_q;
  reg [15:0] base_code_q;
  reg [15:0] temperature_reading_q;
  reg sample_done_q;
  // The converter is calibrated so that the step in diode code is degrees.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meas_cnt_q <= 32'h0;
      base_code_q <= 16'h0000;
      temperature_reading_q <= 16'h0000;
      bias_pulse_out <= 1'b0;
      sample_done_q <= 1'b0;
    end else begin
      sample_done_q <= 1'b0;
      if (meas_cnt_q == TEMP_PERIOD_CYC - 1) begin
        meas_cnt_q <= 32'h0;
      end else begin
        meas_cnt_q <= meas_cnt_q + 32'h1;
      end
      if (meas_cnt_q == 32'h0) begin
        base_code_q <= diode_code_in;
        bias_pulse_out <= 1'b1;
      end else if (meas_cnt_q == BIAS_PULSE_CYC) begin
        temperature_reading_q <= diode_code_in - base_code_q;
        bias_pulse_out <= 1'b0;
        sample_done_q <= 1'b1;
      end
    end
  end

  // ********
  // Retry counting and latch-off
  // ********
  reg timeout_prev_q;
  reg uv_low_seen_q;
  reg [4:0] retry_cnt_q;
  reg latched_off_q;
  wire timeout_edge = timeout_lvl & ~timeout_prev_q;
  wire uv_toggle = uv_ok & uv_low_seen_q;
  // Each fault timeout outside the unlimited setting is one spent attempt; past the limit the gate stays off.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timeout_prev_q <= 1'b0;
      uv_low_seen_q <= 1'b0;
      retry_cnt_q <= 5'd0;
      latched_off_q <= 1'b0;
    end else begin
      timeout_prev_q <= timeout_lvl;
      uv_low_seen_q <= ~uv_ok;
      if (timeout_edge &&
          device_setup_q[2:0] != `RETRY_INFINITE) begin
        if (retry_cnt_q >= retry_limit(device_setup_q[2:0])) begin
          latched_off_q <= 1'b1;
        end else begin
          retry_cnt_q <= retry_cnt_q + 5'd1;
        end
      end else if (uv_toggle) begin
        latched_off_q <= 1'b0;
        retry_cnt_q <= 5'd0;
      end
    end
  end

  // ********
  // Fault flags, alert and gate
  // ********
  reg ot_warn_q;
  reg ot_trip_q;
  reg shorted_q;
  reg uv_flag_q;
  reg ov_flag_q;
  reg rearm_needed_q;
  wire warn_hit = sample_done_q &&
                  temperature_reading_q > overtemp_warn_limit_q;
  wire trip_hit = sample_done_q &&
                  temperature_reading_q > overtemp_fault_limit_q;
  wire gate_cmd_low = ~gate_on_out;
  wire short_hit = sense_short && (gate_low || gate_cmd_low);
  wire op_write = stb_lo && cmd_q == `CMD_OUTPUT_ON_OFF;
  wire [15:0] diag_word = {8'h00, shorted_q, ot_trip_q, ot_warn_q,
                           latched_off_q, uv_flag_q, ov_flag_q, 2'b00};

  // Sticky flags: a new event in the clearing cycle survives the clear.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ot_warn_q <= 1'b0;
      ot_trip_q <= 1'b0;
      shorted_q <= 1'b0;
      uv_flag_q <= 1'b0;
      ov_flag_q <= 1'b0;
      rearm_needed_q <= 1'b0;
    end else begin
      ot_warn_q <= warn_hit | (ot_warn_q & ~clear_cmd);
      ot_trip_q <= trip_hit | (ot_trip_q & ~clear_cmd);
      shorted_q <= short_hit | (shorted_q & ~clear_cmd);
      uv_flag_q <= ~uv_ok | (uv_flag_q & ~clear_cmd);
      ov_flag_q <= ov_high | (ov_flag_q & ~clear_cmd);
      // Restart needs the flag gone and an off write before the on write.
      if (trip_hit) begin
        rearm_needed_q <= 1'b1;
      end else if (op_write && byte_val == `OUTPUT_OFF_VALUE &&
                   !ot_trip_q) begin
        rearm_needed_q <= 1'b0;
      end
    end
  end

  // Outputs are registered so that pin timing is one clean flop.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gate_on_out <= 1'b0;
      smb_alert_out <= 1'b0;
      smb_alert_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      gate_on_out <= supply_ok && uv_ok && !ov_high &&
                     output_on_off_q == `OUTPUT_ON_VALUE &&
                     !ot_trip_q && !trip_hit &&
                     !rearm_needed_q && !latched_off_q;
      smb_alert_oe_out <= |(diag_word & ~alert_suppress_mask_q);
    end
  end

  // ********
  // Read data
  // ********
  // Latch-off reads live, never sticky.
  always @* begin
    case (cmd_q)
      `CMD_OUTPUT_ON_OFF: rd_data = {8'h00, output_on_off_q};
      `CMD_OVERTEMP_FAULT_LIMIT: rd_data = overtemp_fault_limit_q;
      `CMD_OVERTEMP_WARN_LIMIT: rd_data = overtemp_warn_limit_q;
      `CMD_VENDOR_STATUS_BYTE: rd_data = {8'h00, shorted_q, 7'h00};
      `CMD_TEMPERATURE_READING: rd_data = temperature_reading_q;
      `CMD_ALERT_SUPPRESS_MASK: rd_data = alert_suppress_mask_q;
      `CMD_DEVICE_SETUP: rd_data = {8'h00, device_setup_q};
      `CMD_DIAGNOSTIC_STATUS: rd_data = diag_word;
      default: rd_data = 16'hffff;
    endcase
  end
endmodule // hotswap_fault_supervisor

// ---- tb/hotswap_fault_supervisor_asserts.sv ----
// Port-level assertions for the hot-swap supervisor.
`timescale 1ns/1ps
module hotswap_fault_supervisor_asserts #(
  parameter TEMP_PERIOD_CYC = 200,
  parameter BIAS_PULSE_CYC = 20
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire smb_alert_out,
  input wire smb_alert_oe_out,
  input wire bias_pulse_out,
  input wire undervoltage_enable_input,
  input wire overvoltage_input,
  input wire gate_on_out
);
  // ********
  // Helpers and assertions
  // ********
  logic prev_q;
  logic seen_q;
  int hi_q;
  int per_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Counters hold the pulse high time and its rise-to-rise spacing.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
      hi_q <= 0;
      per_q <= 0;
    end else begin
      prev_q <= bias_pulse_out;
      seen_q <= seen_q | (bias_pulse_out & !prev_q);
      hi_q <= bias_pulse_out ? hi_q + 1 : 0;
      per_q <= (bias_pulse_out & !prev_q) ? 1 : per_q + 1;
    end
  end
  a_pulse_width: assert property (
    prev_q && !bias_pulse_out |-> hi_q == BIAS_PULSE_CYC)
    else $error("bias pulse length wrong");
  a_pulse_period: assert property (
    bias_pulse_out && !prev_q && seen_q |-> per_q == TEMP_PERIOD_CYC)
    else $error("bias pulse period wrong");
  a_uv_fall: assert property (
    $fell(undervoltage_enable_input) |-> ##[1:4] !gate_on_out)
    else $error("gate late after enable fell");
  a_uv_hold: assert property (
    !undervoltage_enable_input [*5] |-> !gate_on_out)
    else $error("gate on with enable low");
  a_ov_rise: assert property (
    $rose(overvoltage_input) |-> ##[1:4] !gate_on_out)
    else $error("gate late after overvoltage");
  a_ov_hold: assert property (
    overvoltage_input [*5] |-> !gate_on_out)
    else $error("gate on with overvoltage");
  a_gate_rise: assert property (
    $rose(gate_on_out) |-> undervoltage_enable_input && !overvoltage_input)
    else $error("gate rose with input bad");
  a_alert_low: assert property (
    smb_alert_oe_out |-> !smb_alert_out)
    else $error("alert line not pulled low");
  c_gate_off: cover property ($fell(gate_on_out));
  c_alert: cover property ($rose(smb_alert_oe_out));
  c_pulse: cover property (bias_pulse_out && !prev_q && seen_q);
endmodule // hotswap_fault_supervisor_asserts
bind hotswap_fault_supervisor hotswap_fault_supervisor_asserts #(
  .TEMP_PERIOD_CYC(TEMP_PERIOD_CYC), .BIAS_PULSE_CYC(BIAS_PULSE_CYC)) chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .smb_alert_out(smb_alert_out),
  .smb_alert_oe_out(smb_alert_oe_out), .bias_pulse_out(bias_pulse_out),
  .undervoltage_enable_input(undervoltage_enable_input),
  .overvoltage_input(overvoltage_input), .gate_on_out(gate_on_out));

// ---- tb/smb_host.sv ----
// Management bus host model that owns the bus clock and pulls data low.
`timescale 1ns/1ps
module smb_host (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out,
  output logic rd_valid_out,
  output logic [15:0] rd_word_out
);
  // ********
  // Bus cycles
  // ********
  logic nak_q = 1'b0;
  // The clock idles high and data is released between frames.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_word_out = 16'h0000;
  end
  // One 48 ns slot; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    #12 sda_low_out = !b;
    #12 scl_out = 1'b1;
    #24 r = sda_in;
  endtask
  // A released ninth bit that reads high is a refusal.
  task automatic byte_io(input logic [7:0] d, input logic ak,
                         output logic [7:0] r);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ak, x);
    if (d != 8'hff) nak_q = nak_q | x;
  endtask
  // Data falls while the clock is high; also serves as repeated start.
  task automatic start;
    scl_out = 1'b0;
    #12 sda_low_out = 1'b0;
    #12 scl_out = 1'b1;
    #12 sda_low_out = 1'b1;
    #12 scl_out = 1'b0;
  endtask
  // Data rises while the clock is high, then the bus rests.
  task automatic stop;
    scl_out = 1'b0;
    #12 sda_low_out = 1'b1;
    #12 scl_out = 1'b1;
    #12 sda_low_out = 1'b0;
    #24;
  endtask
  // Whole transfer, low byte first; a read word goes out on a strobe.
  task automatic xfer(input logic [6:0] a, input logic [7:0] c,
                      input int n, input logic [15:0] w, input logic rd);
    logic [7:0] lo, hi, t;
    nak_q = 1'b0;
    start();
    byte_io({a, 1'b0}, 1'b1, t);
    byte_io(c, 1'b1, t);
    if (n > 0) byte_io(w[7:0], 1'b1, t);
    if (n > 1) byte_io(w[15:8], 1'b1, t);
    if (rd) begin
      start();
      byte_io({a, 1'b1}, 1'b1, t);
      byte_io(8'hff, 1'b0, lo);
      byte_io(8'hff, 1'b1, hi);
      rd_word_out = {hi, lo};
      rd_valid_out = 1'b1;
      #1 rd_valid_out = 1'b0;
    end
    stop();
  endtask
endmodule // smb_host

// ---- tb/hotswap_fault_supervisor_tb.sv ----
// Self-checking bench for the hot-swap supervisor.
`timescale 1ns/1ps
module hotswap_fault_supervisor_tb;
  // ********
  // Signals, instances and helpers
  // ********
  localparam int TP = 200;
  localparam int BP = 20;
  localparam logic [6:0] AB = 7'h40;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic uv = 1'b1, ov = 1'b0, sense = 1'b0, glow = 1'b0, tmo = 1'b0;
  logic sup = 1'b0;
  logic [15:0] diode = 16'h0000, base, temp = 16'h0000;
  logic [15:0] tv[3] = '{16'h0064, 16'h007e, 16'h0097};
  int lim[7] = '{0, 1, 2, 4, 8, 16, 20};
  logic [5:0] st;
  logic [6:0] adr;
  logic [39:0] note;
  logic [39:0] exp_q[$];
  int seed = 25, miscompares = 0, comparisons = 0, cyc = 0;
  wire sda_oe, scl, sda_low, alert_oe, rd_v, gate, bias;
  wire [15:0] rd_w;
  wire sda_w = !(sda_low | sda_oe);
  hotswap_fault_supervisor #(.TEMP_PERIOD_CYC(TP), .BIAS_PULSE_CYC(BP),
    .ADDR_BASE(AB)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(sda_oe), .smb_alert_out(),
    .smb_alert_oe_out(alert_oe), .diode_code_in(diode), .bias_pulse_out(bias),
    .undervoltage_enable_input(uv), .overvoltage_input(ov),
    .sense_over_short_in(sense), .gate_low_in(glow), .fault_timeout_in(tmo),
    .supply_ready_in(sup), .address_strap_a(st[1:0]),
    .address_strap_b(st[3:2]), .address_strap_c(st[5:4]), .gate_on_out(gate));
  smb_host host (.sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low),
    .rd_valid_out(rd_v), .rd_word_out(rd_w));
  // Clock at 200 MHz.
  always #2.5 clk_in = !clk_in;
  // The diode code steps up by the chosen temperature during the pulse.
  always @(posedge clk_in) diode <= bias ? base + temp : base;
  // A hang is cut short well past the expected run length.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end
  // Each finished read is matched against the oldest note.
  always @(posedge rd_v) begin
    note = exp_q.pop_front();
    check($sformatf("read %h", note[39:32]), rd_w & note[31:16], note[15:0]);
  end
  task automatic check(input string nm, input logic [15:0] s, e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic gk(input logic e);
    check("gate", {15'h0, gate}, {15'h0, e});
  endtask
  task automatic ak(input logic e);
    check("alert", {15'h0, alert_oe}, {15'h0, e});
  endtask
  // Strap digit: ground, open, or tied high.
  function automatic logic [6:0] dg(input logic [1:0] p);
    return p[1] ? 7'h02 : {6'h00, p[0]};
  endfunction
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] w);
    host.xfer(adr, c, n, w, 1'b0);
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] m, e);
    exp_q.push_back({c, m, e & m});
    host.xfer(adr, c, 0, 16'h0000, 1'b1);
    @(posedge clk_in);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse;
    tmo <= 1'b1;
    waitc(4);
    tmo <= 1'b0;
    waitc(4);
  endtask
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ********
  // Test sequence
  // ********
  initial begin
    st = 6'($random(seed));
    base = 16'($random(seed)) & 16'h0fff;
    adr = AB + dg(st[1:0]) + 7'h03 * dg(st[3:2]) + 7'h09 * dg(st[5:4]);
    waitc(8);
    reset_n_in <= 1'b1;
    sup <= 1'b1;
    waitc(8);
    rd(8'h4f, 16'hffff, 16'h0096);
    rd(8'h51, 16'hffff, 16'h007d);
    rd(8'h20, 16'hffff, 16'hffff);
    gk(1'b1);
    $display("test defaults done");
    foreach (tv[i]) begin
      temp <= tv[i];
      waitc(2 * TP);
      rd(8'h8d, 16'hffff, tv[i]);
      ak(tv[i] > 16'h007d);
      gk(tv[i] <= 16'h0096);
    end
    wr(8'h51, 2, 16'h00c8);
    wr(8'h4f, 2, 16'h00fa);
    rd(8'h51, 16'hffff, 16'h00c8);
    wr(8'h05, 0, 16'h0000);
    wr(8'h03, 1, 16'h0000);
    wr(8'h03, 1, 16'h0080);
    waitc(2 * TP);
    gk(1'b1);
    ak(1'b0);
    $display("test temperature done");
    uv <= 1'b0;
    waitc(6);
    gk(1'b0);
    uv <= 1'b1;
    ov <= 1'b1;
    waitc(6);
    gk(1'b0);
    ov <= 1'b0;
    waitc(6);
    gk(1'b1);
    rd(8'h51, 16'hffff, 16'h00c8);
    wr(8'h05, 0, 16'h0000);
    $display("test enable done");
    for (int k = 0; k < 3; k++) begin
      if (k == 1) wr(8'h03, 1, 16'h0000);
      if (k == 2) wr(8'hd8, 2, 16'h0080);
      glow <= (k == 0);
      sense <= 1'b1;
      waitc(6);
      rd(8'he1, 16'h0080, 16'h0080);
      rd(8'h80, 16'h0080, 16'h0080);
      ak(k < 2);
      sense <= 1'b0;
      glow <= 1'b0;
      wr(8'h05, 0, 16'h0000);
    end
    wr(8'h03, 1, 16'h0080);
    gk(1'b1);
    $display("test shorted switch done");
    for (int k = 0; k < 7; k++) begin
      wr(8'hd9, 1, 16'(k));
      repeat (lim[k]) pulse();
      gk(1'b1);
      if (k < 6) begin
        pulse();
        gk(1'b0);
        rd(8'he1, 16'h0010, 16'h0010);
        uv <= 1'b0;
        waitc(6);
        uv <= 1'b1;
        waitc(6);
        gk(1'b1);
        wr(8'h05, 0, 16'h0000);
      end
    end
    $display("test retry done");
    wr(8'h51, 2, 16'h0033);
    reset_n_in <= 1'b0;
    sup <= 1'b0;
    st <= 6'($random(seed));
    waitc(8);
    reset_n_in <= 1'b1;
    waitc(8);
    adr = AB + dg(st[1:0]) + 7'h03 * dg(st[3:2]) + 7'h09 * dg(st[5:4]);
    rd(8'h51, 16'hffff, 16'hffff);
    check("nak", {15'h0, host.nak_q}, 16'h0001);
    sup <= 1'b1;
    waitc(8);
    rd(8'h51, 16'hffff, 16'h007d);
    check("nak", {15'h0, host.nak_q}, 16'h0000);
    $display("test reset done");
    test_done();
  end
endmodule // hotswap_fault_supervisor_tb
